// >>> src/pdm_pkg.sv
package pdm_pkg;
  // Printed offsets are not all word aligned: they are indices, byte address is four times them
  localparam logic [31:0] STANDBY_CONTROL_IDX = 32'hFFFFFF82;
  localparam logic [31:0] STANDBY_CONTROL_TWO_IDX = 32'hFFFFFF88;
  localparam logic [31:0] STANDBY_CONTROL_ADDR = {STANDBY_CONTROL_IDX[29:0], 2'b00};
  localparam logic [31:0] STANDBY_CONTROL_TWO_ADDR = {STANDBY_CONTROL_TWO_IDX[29:0], 2'b00};
  localparam logic [7:0] STANDBY_CONTROL_RESET = 8'h00;
  localparam logic [7:0] STANDBY_CONTROL_TWO_RESET = 8'h00;
  localparam logic [7:0] STANDBY_CONTROL_WMASK = 8'h97;
  localparam int STANDBY_SELECT_BIT = 7;
  localparam int OSC_KEEP_BIT = 4;
  localparam int TIMER_STOP_BIT = 2;
  localparam int RTC_STOP_BIT = 1;
  localparam int SERIAL_STOP_BIT = 0;
  localparam logic [31:0] RDATA_ZERO = 32'h00000000;

  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_NORMAL = 3'b001,
    ST_SLEEP = 3'b010,
    ST_STANDBY = 3'b011,
    ST_WAKE = 3'b100,
    ST_HWSTBY = 3'b101
  } pd_state_t;

  localparam logic [1:0] PS_RESET = 2'b11;
  localparam logic [1:0] PS_SLEEP = 2'b10;
  localparam logic [1:0] PS_STANDBY = 2'b01;
  localparam logic [1:0] PS_NORMAL = 2'b00;
endpackage : pdm_pkg

// >>> src/power_down_mode_control.sv
// Added by the designer: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module power_down_mode_control
  import pdm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic manual_reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic halt_exec,
  input wire logic int_accept,
  input wire logic wakeup_int,
  input wire logic wdt_overflow,
  input wire logic hw_standby_request_n,
  input wire logic rtc_start,
  input wire logic timer_clk_from_rtc,
  output logic proc_state_upper,
  output logic proc_state_lower,
  output logic wakeup_n,
  output logic cpu_halt,
  output logic osc_run,
  output logic periph_run,
  output logic mem_self_refresh,
  output logic timer_clk_en,
  output logic rtc_if_clk_en,
  output logic rtc_count_en,
  output logic serial_clk_en,
  output logic timer_pin_hold,
  output logic serial_pin_reset
);

////////////////////////////////////////////////////////////////////////////////
  logic [7:0] standby_control_q;
  logic [7:0] standby_control_two_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic setup;
  logic wr_en;
  logic hit_one;
  logic hit_two;
  pd_state_t state_q;
  pd_state_t state_d;

  assign setup = psel && !penable;
  assign hit_one = (paddr == STANDBY_CONTROL_ADDR);
  assign hit_two = (paddr == STANDBY_CONTROL_TWO_ADDR);
  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q && psel && penable;

  // Only the power-on reset clears these; manual reset leaves them alone
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      standby_control_q <= STANDBY_CONTROL_RESET;
      standby_control_two_q <= STANDBY_CONTROL_TWO_RESET;
    end
    else if (wr_en && hit_one)
    begin
      standby_control_q <= pwdata[7:0] & STANDBY_CONTROL_WMASK;
    end
    else if (wr_en && hit_two)
    begin
      standby_control_two_q <= pwdata[7:0];
    end
  end

  // Read data is captured in the setup cycle so the access phase needs no wait
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= RDATA_ZERO;
      pslverr_q <= 1'b0;
    end
    else if (setup)
    begin
      pslverr_q <= !(hit_one || hit_two);
      if (hit_one)
      begin
        prdata_q <= {24'h000000, standby_control_q & STANDBY_CONTROL_WMASK};
      end
      else if (hit_two)
      begin
        prdata_q <= {24'h000000, standby_control_two_q};
      end
      else
      begin
        prdata_q <= RDATA_ZERO;
      end
    end
  end

////////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_RESET:
        state_d = ST_NORMAL;
      ST_NORMAL:
        if (halt_exec)
        begin
          if (standby_control_q[STANDBY_SELECT_BIT])
            state_d = ST_STANDBY;
          else
            state_d = ST_SLEEP;
        end
      ST_SLEEP:
        if (int_accept)
          state_d = ST_NORMAL;
      ST_STANDBY:
        if (int_accept || wakeup_int)
          state_d = ST_WAKE;
      ST_WAKE:
        if (wdt_overflow)
          state_d = ST_NORMAL;
      ST_HWSTBY:
        state_d = ST_HWSTBY;
      default:
        state_d = ST_RESET;
    endcase
    // Pin standby outranks everything except power-on reset
    if (state_q != ST_HWSTBY && !manual_reset_n)
      state_d = ST_RESET;
    if (!hw_standby_request_n)
      state_d = ST_HWSTBY;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= ST_RESET;
    else
      state_q <= state_d;
  end

////////////////////////////////////////////////////////////////////////////////
  logic in_standby_select;
  logic in_hw;
  logic run_all;
  assign in_standby_select = (state_d == ST_STANDBY) || (state_d == ST_WAKE);
  assign in_hw = (state_d == ST_HWSTBY);
  assign run_all = !in_standby_select && !in_hw;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      proc_state_upper <= PS_RESET[1];
      proc_state_lower <= PS_RESET[0];
      wakeup_n <= 1'b1;
      cpu_halt <= 1'b1;
      osc_run <= 1'b1;
      periph_run <= 1'b1;
      mem_self_refresh <= 1'b0;
    end
    else
    begin
      case (state_d)
        ST_RESET:
          {proc_state_upper, proc_state_lower} <= PS_RESET;
        ST_SLEEP:
          {proc_state_upper, proc_state_lower} <= PS_SLEEP;
        ST_NORMAL:
          {proc_state_upper, proc_state_lower} <= PS_NORMAL;
        default:
          {proc_state_upper, proc_state_lower} <= PS_STANDBY;
      endcase
      wakeup_n <= (state_d != ST_WAKE);
      cpu_halt <= (state_d != ST_NORMAL);
      osc_run <= !in_hw && !(in_standby_select && !standby_control_q[OSC_KEEP_BIT]);
      periph_run <= run_all;
      mem_self_refresh <= !run_all;
    end
  end

  // Module clock gates and pin controls, from the stop bits and the power-down state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_clk_en <= 1'b1;
      rtc_if_clk_en <= 1'b1;
      rtc_count_en <= 1'b1;
      serial_clk_en <= 1'b1;
      timer_pin_hold <= 1'b0;
      serial_pin_reset <= 1'b0;
    end
    else
    begin
      // Timer on the counter's output survives standby but never pin standby
      timer_clk_en <= !standby_control_q[TIMER_STOP_BIT] && !in_hw
        && (run_all || timer_clk_from_rtc);
      rtc_if_clk_en <= !standby_control_q[RTC_STOP_BIT] && run_all;
      // Counter is not stopped by its stop bit, only the register interface is
      rtc_count_en <= run_all || rtc_start;
      serial_clk_en <= !standby_control_q[SERIAL_STOP_BIT] && run_all;
      timer_pin_hold <= standby_control_q[TIMER_STOP_BIT];
      serial_pin_reset <= standby_control_q[SERIAL_STOP_BIT];
    end
  end

////////////////////////////////////////////////////////////////////////////////
  sleep_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == ST_NORMAL && halt_exec && !standby_control_q[STANDBY_SELECT_BIT]
    && manual_reset_n && hw_standby_request_n
    |=> state_q == ST_SLEEP ##0 {proc_state_upper, proc_state_lower} == PS_SLEEP)
    else $error("sleep not entered");

  standby_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == ST_NORMAL && halt_exec && standby_control_q[STANDBY_SELECT_BIT]
    && manual_reset_n && hw_standby_request_n
    |=> mem_self_refresh && !periph_run && cpu_halt)
    else $error("standby not entered");

  sleep_exit_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == ST_SLEEP && int_accept && manual_reset_n && hw_standby_request_n
    |=> state_q == ST_NORMAL && !cpu_halt)
    else $error("sleep not left on interrupt");

  hw_standby_a: assert property (@(posedge pclk) disable iff (!presetn)
    !hw_standby_request_n |=> state_q == ST_HWSTBY ##1 state_q == ST_HWSTBY)
    else $error("pin standby lost");

  hw_timer_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == ST_HWSTBY |-> !timer_clk_en)
    else $error("timer runs in pin standby");

  state_pins_a: assert property (@(posedge pclk) disable iff (!presetn)
    !manual_reset_n && hw_standby_request_n && state_q != ST_HWSTBY
    |=> proc_state_upper && proc_state_lower)
    else $error("reset code missing on state pins");

  wake_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(wakeup_n) |-> $past(state_q) == ST_STANDBY)
    else $error("wake indicator fell outside standby");

  reg_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    !manual_reset_n && !(wr_en && hit_one) |=> $stable(standby_control_q))
    else $error("manual reset changed register");

  reserved_a: assert property (@(posedge pclk) disable iff (!presetn)
    (standby_control_q & ~STANDBY_CONTROL_WMASK) == 8'h00)
    else $error("reserved bits set");

  osc_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == ST_STANDBY && !in_hw |-> osc_run == standby_control_q[OSC_KEEP_BIT])
    else $error("oscillator control wrong");

  serial_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    standby_control_q[SERIAL_STOP_BIT] |=> !serial_clk_en)
    else $error("serial clock not stopped");

  rtc_if_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(standby_control_q[RTC_STOP_BIT]) && $past(run_all) |-> !rtc_if_clk_en && rtc_count_en)
    else $error("counter interface gating wrong");

  // Outputs follow the next state, so checks one edge later compare against past inputs
  sleep_run_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == ST_SLEEP |-> osc_run && periph_run && !mem_self_refresh && cpu_halt)
    else $error("sleep stopped the wrong units");

  halt_ignored_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == ST_SLEEP && halt_exec && !int_accept && manual_reset_n
    && hw_standby_request_n |=> state_q == ST_SLEEP)
    else $error("halt acted outside normal operation");

  osc_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    in_standby_select && !standby_control_q[OSC_KEEP_BIT] |=> !osc_run)
    else $error("oscillator kept running in standby");

  periph_halt_a: assert property (@(posedge pclk) disable iff (!presetn)
    in_standby_select || in_hw |=> !periph_run && !serial_clk_en && !rtc_if_clk_en)
    else $error("peripheral clocks run in standby");

  manual_exit_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == ST_STANDBY && !manual_reset_n && hw_standby_request_n
    |=> state_q == ST_RESET && proc_state_upper && proc_state_lower)
    else $error("manual reset did not end standby");

  standby_select_counter_a: assert property (@(posedge pclk) disable iff (!presetn)
    in_standby_select |=> rtc_count_en == $past(rtc_start))
    else $error("counter run wrong in standby");

  standby_select_timer_a: assert property (@(posedge pclk) disable iff (!presetn)
    in_standby_select && !timer_clk_from_rtc |=> !timer_clk_en)
    else $error("timer runs in standby without counter clock");

  hw_outputs_a: assert property (@(posedge pclk) disable iff (!presetn)
    in_hw |=> cpu_halt && !osc_run && mem_self_refresh)
    else $error("pin standby outputs wrong");

  hw_exit_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == ST_HWSTBY |=> state_q == ST_HWSTBY)
    else $error("pin standby left without power-on reset");

  hw_counter_a: assert property (@(posedge pclk) disable iff (!presetn)
    in_hw |=> rtc_count_en == $past(rtc_start))
    else $error("counter run wrong in pin standby");

  pin_levels_a: assert property (@(posedge pclk) disable iff (!presetn)
    timer_pin_hold == $past(standby_control_q[TIMER_STOP_BIT])
    && serial_pin_reset == $past(standby_control_q[SERIAL_STOP_BIT]))
    else $error("module standby pin control wrong");

  normal_pins_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == ST_NORMAL |-> !proc_state_upper && !proc_state_lower && !cpu_halt)
    else $error("normal code missing on state pins");

  wake_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == ST_STANDBY && wakeup_int && manual_reset_n && hw_standby_request_n
    |=> !wakeup_n)
    else $error("wake indicator not asserted");

  wake_release_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == ST_WAKE && wdt_overflow && manual_reset_n && hw_standby_request_n
    |=> wakeup_n && !cpu_halt)
    else $error("wake indicator not released on overflow");

  read_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pwrite && hit_one
    |-> (prdata[7:0] & ~STANDBY_CONTROL_WMASK) == 8'h00)
    else $error("reserved bits read back nonzero");

  timer_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    standby_control_q[TIMER_STOP_BIT] |=> !timer_clk_en)
    else $error("timer clock not stopped");

  cov_sleep_c: cover property (@(posedge pclk) disable iff (!presetn)
    state_q == ST_SLEEP ##1 state_q == ST_NORMAL);
  cov_wake_c: cover property (@(posedge pclk) disable iff (!presetn)
    state_q == ST_WAKE ##1 state_q == ST_NORMAL);
  cov_hw_c: cover property (@(posedge pclk) disable iff (!presetn)
    state_q == ST_HWSTBY);
  cov_standby_select_c: cover property (@(posedge pclk) disable iff (!presetn)
    state_q == ST_STANDBY ##1 state_q == ST_WAKE);
  cov_mreset_c: cover property (@(posedge pclk) disable iff (!presetn)
    state_q == ST_STANDBY ##1 state_q == ST_RESET);

endmodule : power_down_mode_control
`default_nettype wire

// >>> test/cpu_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module cpu_core_model
  import pdm_pkg::*;
(
  input wire logic pclk,
  output var logic psel,
  output var logic penable,
  output var logic pwrite,
  output var logic [31:0] paddr,
  output var logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output var logic [3:0] ev
);
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, ev} = '0;
  end
  ////////////////////////////////////////////////////////////////
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data bus shows garbage, not the last word
    pwdata <= ~d;
  endtask : xfer
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    // A peripheral access first, before the counter interface is gated
    if (a == STANDBY_CONTROL_ADDR && d[RTC_STOP_BIT]) xfer(1'b0, a, '0, r, e);
    if (a == STANDBY_CONTROL_ADDR) d = d & STANDBY_CONTROL_WMASK;
    xfer(1'b1, a, {24'h000000, d}, r, e);
  endtask : wr
  // Index: 0 halt, 1 interrupt accept, 2 wakeup interrupt, 3 watchdog overflow
  task automatic pulse(input int i);
    @(posedge pclk);
    ev[i] <= 1'b1;
    @(posedge pclk);
    ev[i] <= 1'b0;
    #1;
  endtask : pulse
endmodule : cpu_core_model
`default_nettype wire

// >>> test/power_down_mode_control_test.sv
`timescale 1ns/100ps
`default_nettype none
module power_down_mode_control_test
  import pdm_pkg::*;
;
  logic pclk = 0, presetn = 0, manual_reset_n = 1, hw_standby_request_n = 1;
  logic rtc_start = 0, timer_clk_from_rtc = 0, psel, penable, pwrite, pready, pslverr, e;
  logic [31:0] paddr, pwdata, prdata, r;
  logic [3:0] ev;
  logic [7:0] d;
  logic proc_state_upper, proc_state_lower, wakeup_n, cpu_halt, osc_run, periph_run;
  logic mem_self_refresh, timer_clk_en, rtc_if_clk_en, rtc_count_en, serial_clk_en;
  logic timer_pin_hold, serial_pin_reset;
  int n_errors = 0, num_checks = 0, cyc = 0;
  localparam logic [31:0] SC = STANDBY_CONTROL_ADDR;
  power_down_mode_control u_power_down_mode_control (.pclk, .presetn, .manual_reset_n,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .halt_exec(ev[0]), .int_accept(ev[1]), .wakeup_int(ev[2]), .wdt_overflow(ev[3]),
    .hw_standby_request_n, .rtc_start, .timer_clk_from_rtc, .proc_state_upper,
    .proc_state_lower, .wakeup_n, .cpu_halt, .osc_run, .periph_run, .mem_self_refresh,
    .timer_clk_en, .rtc_if_clk_en, .rtc_count_en, .serial_clk_en, .timer_pin_hold,
    .serial_pin_reset);
  cpu_core_model u_cpu_core_model (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .ev);
  always #10 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x)
    begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, s, x);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  task automatic rd(input logic [31:0] a);
    u_cpu_core_model.xfer(1'b0, a, '0, r, e);
  endtask : rd
  function automatic logic [4:0] gates(input logic [7:0] c);
    return {~c[2], ~c[1], ~c[0], c[2], c[0]};
  endfunction : gates
  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_errors++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h755D));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    chk({proc_state_upper, proc_state_lower}, PS_NORMAL);
    rd(SC);
    chk(r, 32'h00000000);
    rd(STANDBY_CONTROL_TWO_ADDR);
    chk(r, 32'h00000000);
    // Raw writes on purpose set the reserved bits too
    repeat (8)
    begin
      d = $urandom;
      if (d[RTC_STOP_BIT]) rd(SC);
      u_cpu_core_model.xfer(1'b1, SC, {24'h000000, d}, r, e);
      rd(SC);
      chk(r, {24'h000000, d & 8'h97});
      chk(gates(r[7:0]), {timer_clk_en, rtc_if_clk_en, serial_clk_en, timer_pin_hold,
        serial_pin_reset});
    end
    d = $urandom;
    u_cpu_core_model.wr(STANDBY_CONTROL_TWO_ADDR, d);
    rd(STANDBY_CONTROL_TWO_ADDR);
    chk(r, {24'h000000, d});
    rd(SC + 32'h4);
    chk(e, 1'b1);
    chk(r, 32'h00000000);
    u_cpu_core_model.wr(SC, 8'h02);
    u_cpu_core_model.pulse(0);
    chk({proc_state_upper, proc_state_lower}, PS_SLEEP);
    chk({cpu_halt, osc_run, periph_run, mem_self_refresh}, 4'b1110);
    // A second halt while asleep must be ignored
    u_cpu_core_model.pulse(0);
    chk({proc_state_upper, proc_state_lower}, PS_SLEEP);
    u_cpu_core_model.pulse(1);
    chk({proc_state_upper, proc_state_lower, cpu_halt}, 3'b000);
    for (int k = 0; k < 2; k++)
    begin
      d = $urandom;
      rtc_start <= d[0];
      timer_clk_from_rtc <= d[1];
      u_cpu_core_model.wr(SC, k[0] ? 8'h90 : 8'h80);
      u_cpu_core_model.pulse(0);
      chk({proc_state_upper, proc_state_lower}, PS_STANDBY);
      chk({cpu_halt, osc_run, periph_run, mem_self_refresh}, {1'b1, k[0], 2'b01});
      chk({rtc_count_en, timer_clk_en}, {rtc_start, timer_clk_from_rtc});
      u_cpu_core_model.pulse(k[0] ? 1 : 2);
      chk({wakeup_n, proc_state_upper, proc_state_lower}, 3'b001);
      u_cpu_core_model.pulse(3);
      chk({wakeup_n, proc_state_upper, proc_state_lower, cpu_halt}, 4'b1000);
    end
    // Manual reset taken from standby
    u_cpu_core_model.pulse(0);
    chk({proc_state_upper, proc_state_lower}, PS_STANDBY);
    manual_reset_n <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
    chk({proc_state_upper, proc_state_lower}, PS_RESET);
    manual_reset_n <= 1'b1;
    rd(SC);
    chk(r, 32'h00000090);
    chk({proc_state_upper, proc_state_lower}, PS_NORMAL);
    d = $urandom;
    rtc_start <= d[0];
    timer_clk_from_rtc <= 1'b1;
    hw_standby_request_n <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
    chk({proc_state_upper, proc_state_lower}, PS_STANDBY);
    chk({cpu_halt, periph_run, mem_self_refresh}, 3'b101);
    chk({rtc_count_en, timer_clk_en}, {rtc_start, 1'b0});
    hw_standby_request_n <= 1'b1;
    u_cpu_core_model.pulse(1);
    chk({proc_state_upper, proc_state_lower}, PS_STANDBY);
    presetn <= 1'b0;
    @(posedge pclk);
    #1;
    chk({proc_state_upper, proc_state_lower}, PS_RESET);
    presetn <= 1'b1;
    rd(SC);
    chk(r, 32'h00000000);
    chk({proc_state_upper, proc_state_lower}, PS_NORMAL);
    summarize();
  end
endmodule : power_down_mode_control_test
`default_nettype wire
